/* File: lcs_pkg.sv */
// constants and types shared by the launch cutoff sequencer
package lcs_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_CAUSE   = 8'h08;
    localparam logic [7:0] REG_TIME    = 8'h0C;
    localparam logic [7:0] REG_RECYCLE = 8'h10;
    // control register bits
    localparam int CTRL_ARM    = 0;
    localparam int CTRL_DISARM = 1;
    // countdown time, in milliseconds relative to T-0
    localparam int TICK_MS     = 10;
    localparam int T_START_MS  = -187000;
    localparam int T_END_MS    = 6000;
    localparam int T_RCVR_MS   = -17000;
    localparam int T_LATE_MS   = -8900;
    localparam int T_WEND_MS   = -50;
    localparam logic signed [15:0] T_START = 16'(T_START_MS / TICK_MS);
    localparam logic signed [15:0] T_END   = 16'(T_END_MS / TICK_MS);
    localparam logic signed [15:0] T_RCVR  = 16'(T_RCVR_MS / TICK_MS);
    localparam logic signed [15:0] T_LATE  = 16'(T_LATE_MS / TICK_MS);
    localparam logic signed [15:0] T_WEND  = 16'(T_WEND_MS / TICK_MS);
    localparam logic signed [15:0] TIME_RST = 16'h0000;
    // recycle targets, seconds before T-0
    localparam logic [31:0] RECYCLE_SHORT_S = 32'h0000_0528;
    localparam logic [31:0] RECYCLE_LONG_S  = 32'h0001_89C0;
    // engine stagger
    localparam int CLK_HZ      = 20_000_000;
    localparam int STAGGER_MS  = 100;
    localparam int STAGGER_CYC = STAGGER_MS * (CLK_HZ / 1000);
    // engine groups, bit n is engine n+1
    localparam logic [4:0] ORDER_NORMAL = 5'h15;
    localparam logic [4:0] ORDER_PREF   = 5'h1A;
    localparam logic [4:0] ENG_ALL      = 5'h1F;
    localparam logic [4:0] ENG_NONE     = 5'h00;
    // cutoff cause bits
    localparam int CZ_MANUAL = 0;
    localparam int CZ_LOGIC  = 1;
    localparam int CZ_MFV    = 2;
    localparam int CZ_PSU    = 3;
    localparam int CZ_VOLT   = 4;
    localparam int CZ_EDS    = 5;
    localparam int CZ_IU     = 6;
    localparam int CZ_W      = 7;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RUN  = 4'h2,
        ST_CUT  = 4'h4,
        ST_DONE = 4'h8
    } lcs_state_t;
endpackage : lcs_pkg

/* File: lcs_sequencer.sv */
// terminal sequencer with cutoff interlocks and staged engine shutdown
// Operation
// (RULE1) start on T-187 pulse if armed, ready, enabled
// (RULE2) readiness is AND of all monitored items
// (RULE3) run automatically from T-187 s to T+6 s
// (RULE4) no hold once running, only cutoff stops
// (RULE5) manual cutoff honoured until umbilical separation
// (RULE6) six instant interlocks ORed into cutoff; the code ORs seven cause bits
// (RULE7) logic cutoff: stop solenoid or destruct fault
// (RULE8) receiver check only from T-17 s to T-50 ms
// (RULE9) valve fault: both open early, or mismatched
// (RULE10) valve fault stops three, then two 100 ms later
// (RULE11) fault on engine 2 or 4: 2,4,5 first
// (RULE12) fault on engine 1,3,5: 1,3,5 first
// (RULE13) other causes use normal order
// (RULE14) no hold accepted after T-187 s
// (RULE15) interrupt before T-8.9 s: recycle to T-22 min
// (RULE16) interrupt after T-8.9 s: recycle to T-28 h
// (RULE17) operator keeps holds within 5.00 hours
// (RULE18) emergency detection interlock, T-8.9 s to T-50 ms
// (RULE19) instrument unit ready loss, T-8.9 s to T-50 ms
// (RULE20) cutoff on sequencer supply out of tolerance
// (RULE21) cutoff on first stage bus voltage fault
// (RULE22) signed countdown counter drives windows and recycle
// (RULE23) cutoff latches until re-armed
module lcs_sequencer
    import lcs_pkg::*;
#(
    parameter int PREP_N         = 12,
    parameter int STAGGER_CYCLES = STAGGER_CYC
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              count_tick,
    input  wire logic              t187_pulse,
    input  wire logic [PREP_N-1:0] prep_ok,
    input  wire logic              fire_enable,
    input  wire logic              manual_cutoff,
    input  wire logic              umbilical_sep,
    input  wire logic              hold_req,
    input  wire logic              stop_solenoid,
    input  wire logic [1:0]        destruct_fault,
    input  wire logic              rcvr_fault,
    input  wire logic              hypergol_ruptured,
    input  wire logic [9:0]        mfv_open,
    input  wire logic              psu_out_of_tol,
    input  wire logic              main_bus_bad,
    input  wire logic              instr_bus_bad,
    input  wire logic [2:0]        sc_cutoff_cmd,
    input  wire logic [2:0]        emergency_detection_bus_ok,
    input  wire logic              instrument_unit_ready,
    output logic                   cutoff,
    output logic [4:0]             eng_stop,
    output logic                   running,
    output logic                   recycle_long,
    output logic                   hold_granted
);
    localparam int IN_W = 31 + PREP_N;
    localparam int SW   = $clog2(STAGGER_CYCLES + 1);

    function automatic logic in_win(input logic signed [15:0] t,
                                    input logic signed [15:0] lo,
                                    input logic signed [15:0] hi);
        in_win = (t >= lo) && (t <= hi);
    endfunction : in_win

    // valve pair fault: both open before rupture, or one open alone
    function automatic logic mfv_bad(input logic [1:0] v,
                                     input logic hyp);
        mfv_bad = ((&v) && !hyp) || (^v);
    endfunction : mfv_bad

    logic [IN_W-1:0] sync1_q;
    logic [IN_W-1:0] sync2_q;
    logic [PREP_N-1:0] s_prep;
    logic s_tick, s_t187, s_fire, s_man, s_umb, s_hold, s_stop;
    logic [1:0] s_destr;
    logic s_rcvr, s_hyp, s_psu, s_mbus, s_ibus, s_iu;
    logic [2:0] s_sc, s_eds;
    logic [9:0] s_mfv;
    logic tick_prev_q, t187_prev_q;
    logic tick_edge, t187_edge;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {count_tick, t187_pulse, fire_enable, manual_cutoff,
                        umbilical_sep, hold_req, stop_solenoid,
                        destruct_fault, rcvr_fault, hypergol_ruptured,
                        psu_out_of_tol, main_bus_bad, instr_bus_bad,
                        instrument_unit_ready, sc_cutoff_cmd,
                        emergency_detection_bus_ok, mfv_open, prep_ok};
            sync2_q <= sync1_q;
        end
    end

    assign {s_tick, s_t187, s_fire, s_man, s_umb, s_hold, s_stop, s_destr,
            s_rcvr, s_hyp, s_psu, s_mbus, s_ibus, s_iu, s_sc, s_eds,
            s_mfv, s_prep} = sync2_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tick_prev_q <= 1'b0;
            t187_prev_q <= 1'b0;
        end else begin
            tick_prev_q <= s_tick;
            t187_prev_q <= s_t187;
        end
    end
    assign tick_edge = s_tick && !tick_prev_q;
    assign t187_edge = s_t187 && !t187_prev_q;

    lcs_state_t        state_q;
    logic              armed_q;
    logic signed [15:0] time_q;
    logic [CZ_W-1:0]   cause_q;
    logic              pref_q;
    logic [SW-1:0]     stag_q;
    logic              prep_all, start_ok, mfv_pref, wr_ctrl;
    logic [4:0]        mfv_eng;
    logic [CZ_W-1:0]   cz_d;

    // (RULE2) readiness summation
    assign prep_all = &s_prep;
    // (RULE1) start gate
    assign start_ok = armed_q && prep_all && s_fire && t187_edge;

    // (RULE9) per engine valve check
    always_comb begin
        for (int e = 0; e < 5; e++) begin
            mfv_eng[e] = mfv_bad(s_mfv[2*e +: 2], s_hyp);
        end
    end
    // (RULE11) engines 2 and 4 pick preferred order
    assign mfv_pref = mfv_eng[1] || mfv_eng[3];

    // (RULE6) instant interlocks; receiver, emergency detection and unit ready gated by their windows
    always_comb begin
        cz_d = '0;
        if (state_q == ST_RUN) begin
            // (RULE5) manual until separation
            cz_d[CZ_MANUAL] = s_man && !s_umb;
            // (RULE7) logic cutoff with (RULE8) receiver window
            cz_d[CZ_LOGIC]  = s_stop || (|s_destr)
                              || (s_rcvr && in_win(time_q, T_RCVR, T_WEND));
            cz_d[CZ_MFV]    = |mfv_eng;
            // (RULE20) supply tolerance
            cz_d[CZ_PSU]    = s_psu;
            // (RULE21) bus voltage
            cz_d[CZ_VOLT]   = s_mbus || s_ibus;
            // (RULE18) emergency detection window
            cz_d[CZ_EDS]    = in_win(time_q, T_LATE, T_WEND)
                              && ((|s_sc) || !(&s_eds));
            // (RULE19) instrument unit window
            cz_d[CZ_IU]     = in_win(time_q, T_LATE, T_WEND) && !s_iu;
        end
    end

    // a write lands at the edge where the master sees pready high
    assign wr_ctrl = psel && penable && pwrite && pready
                     && (paddr == REG_CTRL);

    // (RULE4) only cutoff or the T+6 s end leaves the run state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (start_ok) state_q <= ST_RUN;
                end
                ST_RUN: begin
                    if (|cz_d) begin
                        state_q <= ST_CUT;
                    // (RULE3) automatic control ends at T+6 s
                    end else if (tick_edge && time_q == T_END - 16'sd1) begin
                        state_q <= ST_DONE;
                    end
                end
                // (RULE23) latched until re-armed
                ST_CUT, ST_DONE: begin
                    if (wr_ctrl && pwdata[CTRL_ARM]) state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
        end else if (state_q == ST_RUN) begin
            armed_q <= 1'b0;
        end else if (wr_ctrl && pwdata[CTRL_ARM]) begin
            armed_q <= 1'b1;
        end else if (wr_ctrl && pwdata[CTRL_DISARM]) begin
            armed_q <= 1'b0;
        end
    end

    // (RULE22) signed countdown time in ticks
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            time_q <= TIME_RST;
        end else if (state_q == ST_IDLE && start_ok) begin
            time_q <= T_START;
        end else if (state_q == ST_RUN && tick_edge) begin
            time_q <= time_q + 16'sd1;
        end
    end

    // cause and order captured at the cutoff instant
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cause_q <= '0;
            pref_q  <= 1'b0;
        end else if (state_q == ST_RUN && (|cz_d)) begin
            cause_q <= cz_d;
            // (RULE13) non valve causes keep normal order
            pref_q  <= cz_d[CZ_MFV] && mfv_pref;
        end else if (state_q != ST_CUT && start_ok) begin
            cause_q <= '0;
            pref_q  <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stag_q <= '0;
        end else if (state_q != ST_CUT) begin
            stag_q <= '0;
        end else if (stag_q != SW'(STAGGER_CYCLES - 1)) begin
            stag_q <= stag_q + SW'(1);
        end
    end

    // (RULE10) three engines at cutoff, the rest after the stagger
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            eng_stop <= ENG_NONE;
        end else if (state_q == ST_RUN && (|cz_d)) begin
            // (RULE12) normal or preferred first group
            eng_stop <= (cz_d[CZ_MFV] && mfv_pref) ? ORDER_PREF
                                                    : ORDER_NORMAL;
        end else if (state_q == ST_CUT
                     && stag_q == SW'(STAGGER_CYCLES - 1)) begin
            eng_stop <= ENG_ALL;
        end else if (state_q != ST_CUT) begin
            eng_stop <= ENG_NONE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cutoff       <= 1'b0;
            running      <= 1'b0;
            recycle_long <= 1'b0;
        end else begin
            cutoff  <= (state_q == ST_RUN && (|cz_d))
                       || (state_q == ST_CUT
                           && !(wr_ctrl && pwdata[CTRL_ARM]));
            running <= (state_q == ST_IDLE && start_ok)
                       || (state_q == ST_RUN && !(|cz_d)
                           && !(tick_edge && time_q == T_END - 16'sd1));
            // (RULE16) late interruption needs long recycle
            if (state_q == ST_RUN && (|cz_d)) begin
                recycle_long <= (time_q >= T_LATE);
            end
        end
    end

    // (RULE14) holds only before the automatic sequence
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            hold_granted <= 1'b0;
        end else begin
            hold_granted <= s_hold && (state_q == ST_IDLE);
        end
    end

    // apb slave, one wait state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
            prdata  <= '0;
            unique case (paddr)
                REG_CTRL:   prdata <= {31'h0, armed_q};
                REG_STATUS: prdata <= {24'h0, recycle_long, cutoff,
                                       prep_all, state_q, armed_q};
                REG_CAUSE:  prdata <= {24'h0, pref_q, cause_q};
                REG_TIME:   prdata <= 32'(time_q);
                // (RULE15) recycle target from interruption time
                REG_RECYCLE: prdata <= recycle_long ? RECYCLE_LONG_S
                                                    : RECYCLE_SHORT_S;
                default:    pslverr <= 1'b1;
            endcase
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    start_gate_a: assert property ( // RULE1
        (state_q == ST_RUN && $past(state_q) == ST_IDLE) |-> $past(start_ok))
        else $error("sequencer started without all interlocks");
    prep_block_a: assert property ( // RULE2
        (state_q == ST_IDLE && !prep_all) |=> state_q != ST_RUN)
        else $error("start despite failed readiness item");
    run_end_a: assert property ( // RULE3
        (state_q == ST_RUN && tick_edge && time_q == T_END - 16'sd1
         && !(|cz_d)) |=> (state_q == ST_DONE && !running))
        else $error("sequence did not end at T+6 s");
    no_hold_a: assert property ( // RULE14
        (state_q != ST_IDLE) |=> !hold_granted)
        else $error("hold granted during automatic sequence");
    manual_cut_a: assert property ( // RULE5
        (state_q == ST_RUN && s_man && !s_umb)
        |=> (cutoff && cause_q[CZ_MANUAL]))
        else $error("manual cutoff not honoured");
    cut_cause_a: assert property ( // RULE6
        $rose(cutoff) |-> ($past(|cz_d) && state_q == ST_CUT))
        else $error("cutoff without an interlock");
    cut_latch_a: assert property ( // RULE23
        (cutoff && !(wr_ctrl && pwdata[CTRL_ARM])) |=> cutoff)
        else $error("cutoff released without re-arm");
    stagger_a: assert property ( // RULE10
        (eng_stop == ENG_ALL && $past(eng_stop) != ENG_ALL)
        |-> $past(stag_q) == SW'(STAGGER_CYCLES - 1))
        else $error("second engine group timing wrong");
    order_a: assert property ( // RULE11
        $rose(cutoff) |-> eng_stop == (($past(cz_d[CZ_MFV]) && $past(mfv_pref))
                                       ? ORDER_PREF : ORDER_NORMAL))
        else $error("wrong first engine group");
    recycle_sel_a: assert property ( // RULE15
        $rose(cutoff) |-> recycle_long == ($past(time_q) >= T_LATE))
        else $error("wrong recycle target");
endmodule : lcs_sequencer

/* File: lcs_far_side.sv */
// far side model: countdown clock, launch consoles and readiness items
module lcs_far_side
#(
    parameter int PREP_N = 12
) (
    input  wire logic         sys_clk,
    output logic              count_tick,
    output logic              t187_pulse,
    output logic              fire_enable,
    output logic              hold_req,
    output logic [PREP_N-1:0] prep_ok
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        count_tick  = 1'b0;
        t187_pulse  = 1'b0;
        fire_enable = 1'b1;
        hold_req    = 1'b0;
        prep_ok     = '1;
    end

    // each tick two cycles high, two low
    task automatic tick_n(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            count_tick <= 1'b1;
            repeat (2) @(posedge sys_clk);
            count_tick <= 1'b0;
            @(posedge sys_clk);
        end
    endtask : tick_n

    task automatic start_pulse();
        @(posedge sys_clk);
        t187_pulse <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t187_pulse <= 1'b0;
    endtask : start_pulse

    task automatic set_console(input logic [PREP_N-1:0] p, input logic f);
        @(posedge sys_clk);
        prep_ok     <= p;
        fire_enable <= f;
    endtask : set_console

    task automatic hold(input logic v);
        @(posedge sys_clk);
        hold_req <= v;
    endtask : hold
endmodule : lcs_far_side

/* File: lcs_sequencer_tb.sv */
// self-checking bench for the launch cutoff sequencer
module lcs_sequencer_tb import lcs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int STG = 20;
    logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        err, count_tick, t187_pulse, fire_enable, hold_req;
    logic        manual_cutoff, umbilical_sep, stop_solenoid, rcvr_fault;
    logic        hypergol_ruptured, psu_out_of_tol, main_bus_bad;
    logic        instr_bus_bad, instrument_unit_ready, cutoff, running;
    logic        recycle_long, hold_granted;
    logic [11:0] prep_ok;
    logic [1:0]  destruct_fault;
    logic [9:0]  mfv_open;
    logic [2:0]  sc_cutoff_cmd, emergency_detection_bus_ok;
    logic [4:0]  eng_stop;
    int          mismatches, n_compared, cyc;

    lcs_sequencer #(.PREP_N(12), .STAGGER_CYCLES(STG)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_tick(count_tick), .t187_pulse(t187_pulse),
        .prep_ok(prep_ok), .fire_enable(fire_enable),
        .manual_cutoff(manual_cutoff), .umbilical_sep(umbilical_sep),
        .hold_req(hold_req), .stop_solenoid(stop_solenoid),
        .destruct_fault(destruct_fault), .rcvr_fault(rcvr_fault),
        .hypergol_ruptured(hypergol_ruptured), .mfv_open(mfv_open),
        .psu_out_of_tol(psu_out_of_tol), .main_bus_bad(main_bus_bad),
        .instr_bus_bad(instr_bus_bad), .sc_cutoff_cmd(sc_cutoff_cmd),
        .emergency_detection_bus_ok(emergency_detection_bus_ok),
        .instrument_unit_ready(instrument_unit_ready),
        .cutoff(cutoff), .eng_stop(eng_stop), .running(running),
        .recycle_long(recycle_long), .hold_granted(hold_granted)
    );
    lcs_far_side #(.PREP_N(12)) far (
        .sys_clk(sys_clk), .count_tick(count_tick),
        .t187_pulse(t187_pulse), .fire_enable(fire_enable),
        .hold_req(hold_req), .prep_ok(prep_ok)
    );

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_hi(ref logic s, input int lim);
        int n;
        n = 0;
        while (s !== 1'b1 && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
    endtask : wait_hi

    task automatic clear_faults();
        manual_cutoff <= 1'b0;
        umbilical_sep <= 1'b0;
        stop_solenoid <= 1'b0;
        destruct_fault <= 2'h0;
        rcvr_fault <= 1'b0;
        hypergol_ruptured <= 1'b0;
        mfv_open <= 10'h000;
        psu_out_of_tol <= 1'b0;
        main_bus_bad <= 1'b0;
        instr_bus_bad <= 1'b0;
        sc_cutoff_cmd <= 3'h0;
        emergency_detection_bus_ok <= 3'h7;
        instrument_unit_ready <= 1'b1;
    endtask : clear_faults

    task automatic arm_start();
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        chk("rearm clear", 32'h0, {26'h0, cutoff, eng_stop});
        far.start_pulse();
        wait_hi(running, 12);
        chk("running", 32'h1, {31'h0, running});
    endtask : arm_start

    task automatic s_regs();
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        apb(1'b0, REG_CTRL, 32'h0);
        chk("armed", 32'h1, rd);
        apb(1'b1, REG_CTRL, 32'h0000_0002);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status idle", 32'h0000_0022, rd);
        far.hold(1'b1);
        repeat (8) @(posedge sys_clk);
        chk("idle hold", 32'h1, {31'h0, hold_granted});
        far.hold(1'b0);
    endtask : s_regs

    task automatic s_refuse();
        for (int i = 0; i < 3; i++) begin
            if (i > 0) apb(1'b1, REG_CTRL, 32'h0000_0001);
            far.set_console((i == 1) ? 12'h7FF : 12'hFFF, i != 2);
            far.start_pulse();
            repeat (8) @(posedge sys_clk);
            chk("no start", 32'h0, {31'h0, running});
        end
        far.set_console(12'hFFF, 1'b1);
    endtask : s_refuse

    task automatic set_fault(input int k);
        @(posedge sys_clk);
        case (k)
            0: manual_cutoff <= 1'b1;
            1: stop_solenoid <= 1'b1;
            2: destruct_fault <= 2'h1;
            3: destruct_fault <= 2'h2;
            4: psu_out_of_tol <= 1'b1;
            5: main_bus_bad <= 1'b1;
            6: instr_bus_bad <= 1'b1;
            12: mfv_open <= 10'h0C0;
            default: mfv_open <= 10'(1 << (2 * (k - 7)));
        endcase
    endtask : set_fault

    // engines 1,3,5 first is 15, engines 2,4,5 first is 1A
    task automatic s_cut(input int k);
        logic [4:0] first;
        int         cz;
        first = (k == 8 || k == 10 || k == 12) ? 5'h1A : 5'h15;
        cz = (k == 0) ? CZ_MANUAL : (k < 4) ? CZ_LOGIC
           : (k == 4) ? CZ_PSU : (k < 7) ? CZ_VOLT : CZ_MFV;
        arm_start();
        set_fault(k);
        wait_hi(cutoff, 10);
        chk("first group", {27'h0, first}, {27'h0, eng_stop});
        repeat (STG - 1) @(posedge sys_clk);
        chk("held group", {27'h0, first}, {27'h0, eng_stop});
        @(posedge sys_clk);
        chk("all engines", 32'h1F, {27'h0, eng_stop});
        chk("run stops", 32'h0, {31'h0, running});
        @(posedge sys_clk);
        clear_faults();
        repeat (8) @(posedge sys_clk);
        chk("latched", 32'h1, {31'h0, cutoff});
        chk("short flag", 32'h0, {31'h0, recycle_long});
        apb(1'b0, REG_RECYCLE, 32'h0);
        chk("short target", 32'(22 * 60), rd);
        apb(1'b0, REG_CAUSE, 32'h0);
        chk("cause", 32'h1, {31'h0, rd[cz]});
    endtask : s_cut

    task automatic s_quiet();
        arm_start();
        @(posedge sys_clk);
        umbilical_sep <= 1'b1;
        hypergol_ruptured <= 1'b1;
        @(posedge sys_clk);
        manual_cutoff <= 1'b1;
        rcvr_fault <= 1'b1;
        sc_cutoff_cmd <= 3'h4;
        emergency_detection_bus_ok <= 3'h6;
        instrument_unit_ready <= 1'b0;
        mfv_open <= 10'h300;
        far.hold(1'b1);
        repeat (10) @(posedge sys_clk);
        chk("quiet", 32'h0, {31'h0, cutoff});
        chk("run hold", 32'h0, {31'h0, hold_granted});
        chk("still run", 32'h1, {31'h0, running});
        far.hold(1'b0);
        set_fault(4);
        wait_hi(cutoff, 10);
        chk("psu cut", 32'h1, {31'h0, cutoff});
        @(posedge sys_clk);
        clear_faults();
    endtask : s_quiet

    task automatic s_long();
        arm_start();
        apb(1'b0, REG_TIME, 32'h0);
        chk("start time", 32'hFFFF_B6F4, rd);
        far.tick_n(17805);
        apb(1'b0, REG_TIME, 32'h0);
        chk("late time", 32'hFFFF_FC81, rd);
        @(posedge sys_clk);
        instrument_unit_ready <= 1'b0;
        repeat (10) @(posedge sys_clk);
        chk("iu early", 32'h0, {31'h0, cutoff});
        far.tick_n(5);
        wait_hi(cutoff, 12);
        chk("iu cut", 32'h1, {31'h0, cutoff});
        chk("normal order", 32'h15, {27'h0, eng_stop});
        chk("long flag", 32'h1, {31'h0, recycle_long});
        apb(1'b0, REG_RECYCLE, 32'h0);
        chk("long target", 32'(28 * 3600), rd);
    endtask : s_long

    initial begin
        rst_n   = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        clear_faults();
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        s_regs();
        s_refuse();
        for (int k = 0; k < 13; k++) s_cut(k);
        s_quiet();
        s_long();
        print_verdict();
    end
endmodule : lcs_sequencer_tb
